// file: bench/acm_chain_ctrl_props.sv
/*
  concurrent checks on the ports of the acquisition chain control block.
  assumes one clock domain; shadow counters follow the clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module acm_chain_ctrl_props
  import acm_pkg::*;
(
  input wire logic ref_clk_i,            // 25 MHz clock
  input wire logic reset_n_i,            // async reset, active low
  input wire logic clk_en_i,             // run enable
  input wire acm_reg_req_t reg_req_i,    // register request
  input wire logic [15:0] conv_result_i, // converter word
  input wire logic [7:0] reg_rdata_o,    // read data
  input wire logic busy_o,               // conversion running
  input wire logic conv_done_o,          // done pulse
  input wire logic conv_start_o,         // start pulse
  input wire acm_analog_t analog_o       // analog settings
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic rep_ff; // shadow of the repeat bit
  logic nxt_rep_ff;
  logic [7:0] run_cnt_ff; // cycles since the last start pulse
  logic [7:0] nxt_run_cnt_ff;
  logic def_wr; // defaults strobe taken this edge
  logic rd0; // read of config zero
  logic rd5; // read of the select register
  // shadow state from the port so no internal probe is needed
  always_comb begin
    rd0 = clk_en_i && reg_req_i.rd && reg_req_i.addr == ADDR_CHAIN_CONFIG_ZERO;
    rd5 = clk_en_i && reg_req_i.rd && reg_req_i.addr == ADDR_INPUT_REFERENCE_SELECT;
    def_wr = clk_en_i && reg_req_i.wr && reg_req_i.addr == ADDR_INPUT_REFERENCE_SELECT && reg_req_i.wdata[POS_DEFAULTS];
    nxt_rep_ff = rep_ff;
    if (clk_en_i && reg_req_i.wr && reg_req_i.addr == ADDR_CHAIN_CONFIG_ZERO) begin
      nxt_rep_ff = reg_req_i.wdata[POS_REPEAT_MODE];
    end else if (def_wr) begin
      nxt_rep_ff = 1'b0; // defaults select single-shot mode
    end
    // saturate so a long idle spell cannot wrap into a false match
    // frozen edges do not count, as the design's counter stands still too
    nxt_run_cnt_ff = run_cnt_ff;
    if (clk_en_i) begin
      nxt_run_cnt_ff = conv_start_o ? 8'h01 : (run_cnt_ff == 8'hff ? run_cnt_ff : run_cnt_ff + 8'h01);
    end
  end
  // registers of the shadow state
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rep_ff <= 1'b0;
      run_cnt_ff <= 8'h00;
    end else begin
      rep_ff <= nxt_rep_ff;
      run_cnt_ff <= nxt_run_cnt_ff;
    end
  end
  sequence s_restart;
    conv_start_o && busy_o;
  endsequence
  sequence s_done_end;
    conv_done_o ##1 !conv_done_o;
  endsequence
  property p_done_time;
    conv_done_o |-> run_cnt_ff == CONV_CYCLES + 8'h01;
  endproperty
  property p_done_pulse;
    conv_done_o |-> s_done_end;
  endproperty
  property p_busy_start;
    conv_start_o |-> busy_o;
  endproperty
  property p_done_busy;
    conv_done_o |-> busy_o == conv_start_o;
  endproperty
  property p_busy_fall;
    $fell(busy_o) |-> conv_done_o || $past(def_wr);
  endproperty
  property p_repeat;
    conv_done_o && rep_ff |-> s_restart;
  endproperty
  property p_start_zero;
    rd0 |=> reg_rdata_o[POS_START] == 1'b0;
  endproperty
  property p_busy_read;
    rd5 |=> reg_rdata_o[POS_BUSY] == $past(busy_o);
  endproperty
  property p_start_pulse;
    conv_start_o && !conv_done_o |=> !conv_start_o;
  endproperty
  property p_latch;
    $changed(analog_o) |-> conv_start_o;
  endproperty
  a_done_time: assert property (p_done_time) else $error("conversion length wrong");
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
  a_busy_start: assert property (p_busy_start) else $error("busy low at start");
  a_done_busy: assert property (p_done_busy) else $error("busy wrong at done");
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell early");
  a_repeat: assert property (p_repeat) else $error("no restart in repeat mode");
  a_start_zero: assert property (p_start_zero) else $error("start bit read as one");
  a_busy_read: assert property (p_busy_read) else $error("busy bit read wrong");
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  a_latch: assert property (p_latch) else $error("settings moved outside a start");
endmodule
bind acm_chain_ctrl acm_chain_ctrl_props i_props (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .clk_en_i(clk_en_i), .reg_req_i(reg_req_i), .conv_result_i(conv_result_i), .reg_rdata_o(reg_rdata_o),
  .busy_o(busy_o), .conv_done_o(conv_done_o), .conv_start_o(conv_start_o), .analog_o(analog_o));
`default_nettype wire

// file: bench/acm_chain_ctrl_test.sv
/*
  self-checking bench for the acquisition chain control block.
  assumes the converter model beside it and the checker bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module acm_chain_ctrl_test;
  import acm_pkg::*;
  logic ref_clk_i = 1'b0; // 40 ns clock
  logic reset_n_i = 1'b0; // held low at start
  logic clk_en = 1'b1; // clock enable
  acm_reg_req_t req = '0; // register request
  logic [15:0] conv_result; // converter word
  logic [15:0] last_word; // word the model delivered
  logic [7:0] rdata; // read data
  logic busy, done, start; // sequencer outputs
  acm_analog_t analog; // decoded settings
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int starts = 0; // start pulses seen
  integer seed = 32'h99a1024b;
  always #20 ref_clk_i = ~ref_clk_i;
  acm_chain_ctrl i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .reg_req_i(req),
    .conv_result_i(conv_result), .reg_rdata_o(rdata), .busy_o(busy), .conv_done_o(done),
    .conv_start_o(start), .analog_o(analog));
  acm_conv_model i_conv (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .conv_start_i(start),
    .conv_done_i(done), .conv_result_o(conv_result), .last_word_o(last_word));
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // cycle count, start count and hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (start === 1'b1) starts <= starts + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      $display("BAD %0t run hung", $time);
      summarize;
    end
  end
  task chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t byte got %h want %h", $time, got, exp);
    end
  endtask
  task chk_analog(input acm_analog_t got, input acm_analog_t exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t settings got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, raised and dropped on falling edges
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge ref_clk_i);
    req.wr = 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge ref_clk_i);
    req.rd = 1'b0;
    d = rdata;
  endtask
  task wait_done;
    int i;
    i = 0;
    do begin
      @(negedge ref_clk_i);
      i++;
    end while (done !== 1'b1 && i < 300);
    chk_reg(8'(i < 300), 8'h01);
  endtask
  // expected decode, worked from the field tables in twelfths
  function automatic acm_analog_t exp_analog(input logic [7:0] c1, c2, c3, c4, c5);
    acm_analog_t e;
    int p, n, ch;
    e = '0;
    if (!c5[5]) begin
      ch = int'(c5[2:1]);
      p = (ch == 3) ? 0 : 2 * ch + 1;
      n = (ch == 3) ? 0 : 2 * ch;
    end else begin
      ch = int'(c5[3:1]);
      p = (ch <= 5) ? ch : 0;
      n = 0;
    end
    e.pos_pin = c5[4] ? 3'(n) : 3'(p);
    e.neg_pin = c5[4] ? 3'(p) : 3'(n);
    e.ref_pair = c5[0] ? SEL_PAIR_32 : SEL_PAIR_10;
    e.mod_en = c1[0];
    e.stage_bypass = ~c1[3:1];
    e.gain1_x12 = (c1[1] && c3[7]) ? GAIN1_HI_X12 : GAIN1_LO_X12;
    e.gain2_x12 = !c1[2] ? GAIN2_00_X12 : c2[5:4] == 2'h0 ? GAIN2_00_X12 : c2[5:4] == 2'h1 ? GAIN2_01_X12 :
      c2[5:4] == 2'h2 ? GAIN2_10_X12 : GAIN2_11_X12;
    e.gain3_x12 = c1[3] ? c3[6:0] : 7'h0c;
    if (c1[2]) begin
      e.off2_neg = c2[3];
      e.off2_steps = (c2[2:0] > 3'h5) ? 3'h5 : c2[2:0];
    end
    if (c1[3]) begin
      e.off3_neg = c4[6];
      e.off3_x12 = c4[5:0];
    end
    return e;
  endfunction
  initial begin
    logic [7:0] cv[6];
    logic [7:0] mk[6];
    logic [7:0] rst[6];
    logic [7:0] v;
    acm_analog_t ea;
    int k, j, n0;
    mk = '{8'h7e, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h3f};
    rst = '{8'h28, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h00};
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    for (j = 0; j < 6; j++) begin
      rd(3'(j), v);
      chk_reg(v, rst[j]);
    end
    $display("test reset_values done");
    // every select code and both references, with random gains and enables
    for (k = 0; k < 64; k++) begin
      for (j = 1; j < 5; j++) cv[j] = 8'($random(seed));
      cv[5] = {2'b00, 5'(k), k[5]};
      for (j = 1; j < 6; j++) wr(3'(j), cv[j]);
      for (j = 1; j < 6; j++) begin
        rd(3'(j), v);
        chk_reg(v, cv[j] & mk[j]);
      end
      wr(ADDR_CHAIN_CONFIG_ZERO, 8'ha8);
      rd(ADDR_INPUT_REFERENCE_SELECT, v);
      chk_reg(v, {2'b10, cv[5][5:0]});
      rd(ADDR_CHAIN_CONFIG_ZERO, v);
      chk_reg(v, 8'h28);
      wait_done;
      ea = exp_analog(cv[1], cv[2], cv[3], cv[4], cv[5]);
      chk_analog(analog, ea);
      rd(ADDR_RESULT_LSB, v);
      chk_reg(v, last_word[7:0]);
      rd(ADDR_RESULT_MSB, v);
      chk_reg(v, last_word[15:8]);
    end
    wr(ADDR_RESULT_LSB, ~last_word[7:0]);
    rd(ADDR_RESULT_LSB, v);
    chk_reg(v, last_word[7:0]);
    $display("test decode done");
    wr(ADDR_BLOCK_ENABLE_BIAS, 8'h09);
    n0 = starts;
    wr(ADDR_CHAIN_CONFIG_ZERO, 8'h2a);
    repeat (3) wait_done;
    wr(ADDR_CHAIN_CONFIG_ZERO, 8'h28);
    wait_done;
    repeat (120) @(negedge ref_clk_i);
    chk_reg(8'(starts - n0), 8'h04);
    chk_reg({7'h00, busy}, 8'h00);
    $display("test repeat done");
    n0 = starts;
    wr(ADDR_CHAIN_CONFIG_ZERO, 8'h80);
    @(negedge ref_clk_i);
    // freeze mid run; the checker's length check catches a slip
    clk_en = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    chk_reg({7'h00, busy}, 8'h01);
    clk_en = 1'b1;
    wr(ADDR_CHAIN_CONFIG_ZERO, 8'h80);
    wait_done;
    wait_done;
    repeat (120) @(negedge ref_clk_i);
    chk_reg(8'(starts - n0), 8'h02);
    $display("test pending done");
    // defaults in mid conversion abort it and start afresh
    n0 = starts;
    wr(ADDR_CHAIN_CONFIG_ZERO, 8'h80);
    repeat (20) @(negedge ref_clk_i);
    wr(ADDR_INPUT_REFERENCE_SELECT, 8'h40);
    wait_done;
    chk_reg(8'(starts - n0), 8'h02);
    wr(ADDR_INPUT_REFERENCE_SELECT, 8'h40);
    wait_done;
    rd(ADDR_BLOCK_ENABLE_BIAS, v);
    chk_reg(v, DEF_BLOCK_ENABLE_BIAS);
    // modulator enable bit cleared once no more runs are wanted; analog_o keeps it on until the next start
    wr(ADDR_BLOCK_ENABLE_BIAS, 8'h00);
    $display("test defaults done");
    summarize;
  end
endmodule
`default_nettype wire

// file: bench/acm_conv_model.sv
/*
  converter stand-in: a fresh word per conversion, garbage between runs.
  assumes start and done pulses from the control block.
*/
`timescale 1ns/1ps
`default_nettype none
module acm_conv_model (
  input wire logic ref_clk_i,       // clock
  input wire logic reset_n_i,       // async reset, active low
  input wire logic conv_start_i,    // start pulse
  input wire logic conv_done_i,     // done pulse
  output logic [15:0] conv_result_o, // result word
  output logic [15:0] last_word_o    // word handed over at the last done
);
  logic [15:0] word_ff; // word of the running conversion
  logic [15:0] cnt_ff; // scrambles the idle output
  logic run_ff; // conversion in progress
  // outside a run the word wobbles, so a late sample shows up as a mismatch
  assign conv_result_o = run_ff ? word_ff : ~word_ff ^ cnt_ff;
  // word steps as an lfsr at each start
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_ff <= 16'h5a3c;
      cnt_ff <= 16'h0000;
      run_ff <= 1'b0;
      last_word_o <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0101;
      if (conv_done_i) begin
        last_word_o <= word_ff;
        run_ff <= 1'b0;
      end
      if (conv_start_i) begin
        word_ff <= {word_ff[14:0], word_ff[15] ^ word_ff[13] ^ word_ff[12] ^ word_ff[10]};
        run_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/acm_chain_ctrl.sv
/*
  acquisition chain control: configuration registers, conversion sequencer
  and decoded analog settings.
  assumes a register port synchronous to ref_clk_i (from the serial link
  front end) and a converter that reports each conversion's result.
*/
// Overview of operation
// - repeat bit in config zero selects mode
// - repeat mode restarts right after completion
// - end of conversion stores result, pulses done
// - single shot runs on start, same sequence
// - top bit zero selects differential pairs
// - bit three swaps positive and negative
// - top bit one: single ended versus input zero
// - reference bit picks pair 1-0 or 3-2
// - enable bits: modulator, stages one to three
// - disabled stages are bypassed
// - stage one gain is one or ten
// - stage two gain codes give 1,2,5,10
// - stage two offset sign-magnitude, 0.2 steps
// - stage three gain equals code twelfths
// - stage three offset sign-magnitude twelfths
// - busy reads one during a conversion
// - start is write only, reads zero
`timescale 1ns/1ps
`default_nettype none
module acm_chain_ctrl
  import acm_pkg::*;
(
  input wire logic ref_clk_i,            // 25 MHz clock
  input wire logic reset_n_i,            // async reset, active low
  input wire logic clk_en_i,             // freezes all state when low
  input wire acm_reg_req_t reg_req_i,    // register access request
  input wire logic [15:0] conv_result_i, // converter output word
  output logic [7:0] reg_rdata_o,        // read data, valid cycle after rd
  output logic busy_o,                   // conversion running
  output logic conv_done_o,              // one-cycle done pulse
  output logic conv_start_o,             // one-cycle start pulse
  output acm_analog_t analog_o           // settings for analog chain
);
  // configuration registers
  logic [7:0] cfg0_ff, nxt_cfg0;  // repeat bit and rate fields
  logic [7:0] cfg1_ff, nxt_cfg1;  // block enable, bias
  logic [7:0] cfg2_ff, nxt_cfg2;  // stage 2 gain/offset, rate
  logic [7:0] cfg3_ff, nxt_cfg3;  // stage 1 and 3 gain
  logic [7:0] cfg4_ff, nxt_cfg4;  // stage 3 offset
  logic [5:0] cfg5_ff, nxt_cfg5;  // input and reference select
  logic [15:0] result_ff, nxt_result; // last conversion result
  logic [7:0] rdata_ff, nxt_rdata;    // registered read data
  // sequencer
  acm_state_t state_ff, nxt_state;    // conversion state
  logic [7:0] cnt_ff, nxt_cnt;        // cycles left in conversion
  logic pend_ff, nxt_pend;            // start request waiting
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic start_ff, nxt_start;
  acm_analog_t analog_ff, nxt_analog; // settings latched at start
  // combinational decode
  logic [2:0] dec_pos, dec_neg;
  logic [1:0] dec_ref;
  logic dec_mod;
  logic [2:0] dec_byp;
  logic [7:0] dec_g1, dec_g2;
  logic [6:0] dec_g3;
  logic dec_o2n, dec_o3n;
  logic [2:0] dec_o2;
  logic [5:0] dec_o3;
  logic wr_start, wr_def; // write strobes for self-clearing bits

  acm_mux_dec u_mux (
    .input_select_field_i(cfg5_ff[5:1]),
    .reference_select_bit_i(cfg5_ff[POS_REFERENCE_SELECT]),
    .pos_pin_o(dec_pos),
    .neg_pin_o(dec_neg),
    .ref_pair_o(dec_ref)
  );

  acm_gain_dec u_gain (
    .enable_i(cfg1_ff[3:0]),
    .first_gain_i(cfg3_ff[POS_FIRST_STAGE_GAIN]),
    .second_gain_i(cfg2_ff[5:4]),
    .second_off_i(cfg2_ff[3:0]),
    .third_gain_i(cfg3_ff[6:0]),
    .third_off_i(cfg4_ff[6:0]),
    .mod_en_o(dec_mod),
    .bypass_o(dec_byp),
    .gain1_o(dec_g1),
    .gain2_o(dec_g2),
    .gain3_o(dec_g3),
    .off2_neg_o(dec_o2n),
    .off2_steps_o(dec_o2),
    .off3_neg_o(dec_o3n),
    .off3_o(dec_o3)
  );

  // register writes and reads; start and defaults are strobes, not stored
  always_comb begin
    nxt_cfg0 = cfg0_ff;
    nxt_cfg1 = cfg1_ff;
    nxt_cfg2 = cfg2_ff;
    nxt_cfg3 = cfg3_ff;
    nxt_cfg4 = cfg4_ff;
    nxt_cfg5 = cfg5_ff;
    nxt_rdata = rdata_ff;
    wr_start = 1'b0;
    wr_def = 1'b0;
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_CHAIN_CONFIG_ZERO: begin
          wr_start = reg_req_i.wdata[POS_START];
          nxt_cfg0 = {1'b0, reg_req_i.wdata[6:1], 1'b0};
        end
        ADDR_BLOCK_ENABLE_BIAS: nxt_cfg1 = reg_req_i.wdata;
        ADDR_STAGE2_GAIN_OFFSET_RATE: nxt_cfg2 = reg_req_i.wdata;
        ADDR_STAGE1_STAGE3_GAIN: nxt_cfg3 = reg_req_i.wdata;
        ADDR_STAGE3_OFFSET: nxt_cfg4 = {1'b0, reg_req_i.wdata[6:0]};
        ADDR_INPUT_REFERENCE_SELECT: begin
          nxt_cfg5 = reg_req_i.wdata[5:0];
          wr_def = reg_req_i.wdata[POS_DEFAULTS];
        end
        default: begin
          // result registers are read only
        end
      endcase
      if (wr_def) begin
        // defaults: chain setup back to reset, modulator on, max speed
        nxt_cfg0 = RST_CHAIN_CONFIG_ZERO;
        nxt_cfg1 = DEF_BLOCK_ENABLE_BIAS;
        nxt_cfg2 = DEF_STAGE2_GAIN_OFFSET_RATE;
        nxt_cfg3 = RST_STAGE1_STAGE3_GAIN;
        nxt_cfg4 = RST_STAGE3_OFFSET;
      end
    end
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ADDR_CHAIN_CONFIG_ZERO: nxt_rdata = cfg0_ff;
        ADDR_BLOCK_ENABLE_BIAS: nxt_rdata = cfg1_ff;
        ADDR_STAGE2_GAIN_OFFSET_RATE: nxt_rdata = cfg2_ff;
        ADDR_STAGE1_STAGE3_GAIN: nxt_rdata = cfg3_ff;
        ADDR_STAGE3_OFFSET: nxt_rdata = cfg4_ff;
        ADDR_INPUT_REFERENCE_SELECT: nxt_rdata = {busy_ff, 1'b0, cfg5_ff};
        ADDR_RESULT_LSB: nxt_rdata = result_ff[7:0];
        ADDR_RESULT_MSB: nxt_rdata = result_ff[15:8];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg0_ff <= RST_CHAIN_CONFIG_ZERO;
      cfg1_ff <= RST_BLOCK_ENABLE_BIAS;
      cfg2_ff <= RST_STAGE2_GAIN_OFFSET_RATE;
      cfg3_ff <= RST_STAGE1_STAGE3_GAIN;
      cfg4_ff <= RST_STAGE3_OFFSET;
      cfg5_ff <= RST_INPUT_REFERENCE_SELECT[5:0];
      rdata_ff <= 8'h00;
    end else if (clk_en_i) begin
      cfg0_ff <= nxt_cfg0;
      cfg1_ff <= nxt_cfg1;
      cfg2_ff <= nxt_cfg2;
      cfg3_ff <= nxt_cfg3;
      cfg4_ff <= nxt_cfg4;
      cfg5_ff <= nxt_cfg5;
      rdata_ff <= nxt_rdata;
    end
  end

  // sequencer: idle waits for a request, run counts down, done stores result
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pend = pend_ff | wr_start; // request waits for current conversion
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_start = 1'b0;
    nxt_result = result_ff;
    nxt_analog = analog_ff;
    case (state_ff)
      ACM_IDLE: begin
        // a defaults strobe written now counts as a request too
        if (nxt_pend || cfg0_ff[POS_REPEAT_MODE] || wr_def) begin
          nxt_state = ACM_RUN;
          nxt_cnt = CONV_CYCLES;
          nxt_pend = 1'b0;
          nxt_busy = 1'b1;
          nxt_start = 1'b1;
          // freeze settings for the whole conversion
          nxt_analog = '{dec_pos, dec_neg, dec_ref, dec_mod, dec_byp, dec_g1, dec_g2,
                         dec_g3, dec_o2n, dec_o2, dec_o3n, dec_o3};
        end
      end
      ACM_RUN: begin
        if (wr_def) begin
          // defaults restart without waiting for the running conversion
          nxt_state = ACM_IDLE;
          nxt_busy = 1'b0;
          nxt_pend = 1'b1; // restart next cycle with the default settings
        end else if (cnt_ff <= 8'h01) begin
          nxt_state = ACM_DONE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ACM_DONE: begin
        nxt_result = conv_result_i;
        nxt_done = 1'b1;
        nxt_busy = 1'b0;
        nxt_state = ACM_IDLE;
        // repeat mode restarts with no idle gap beyond one cycle
        if (cfg0_ff[POS_REPEAT_MODE] || nxt_pend || wr_def) begin
          nxt_state = ACM_RUN;
          nxt_cnt = CONV_CYCLES;
          nxt_pend = 1'b0;
          nxt_busy = 1'b1;
          nxt_start = 1'b1;
          nxt_analog = '{dec_pos, dec_neg, dec_ref, dec_mod, dec_byp, dec_g1, dec_g2,
                         dec_g3, dec_o2n, dec_o2, dec_o3n, dec_o3};
        end
      end
      default: begin
        nxt_state = ACM_IDLE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ACM_IDLE;
      cnt_ff <= 8'h00;
      pend_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      start_ff <= 1'b0;
      result_ff <= 16'h0000;
      analog_ff <= '0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      start_ff <= nxt_start;
      result_ff <= nxt_result;
      analog_ff <= nxt_analog;
    end
  end

  // all outputs straight from flip-flops
  assign reg_rdata_o = rdata_ff;
  assign busy_o = busy_ff;
  assign conv_done_o = done_ff;
  assign conv_start_o = start_ff;
  assign analog_o = analog_ff;
endmodule
`default_nettype wire

// file: hw/acm_gain_dec.sv
/*
  combinational decode of enables, gains and offsets into twelfths and 0.2 steps.
  assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module acm_gain_dec
  import acm_pkg::*;
(
  input wire logic [3:0] enable_i,   // block enables
  input wire logic first_gain_i,     // stage 1 gain bit
  input wire logic [1:0] second_gain_i, // stage 2 gain code
  input wire logic [3:0] second_off_i,  // stage 2 offset code
  input wire logic [6:0] third_gain_i,  // stage 3 gain code
  input wire logic [6:0] third_off_i,   // stage 3 offset code
  output logic mod_en_o,             // modulator on
  output logic [2:0] bypass_o,       // stage bypasses
  output logic [7:0] gain1_o,        // twelfths
  output logic [7:0] gain2_o,        // twelfths
  output logic [6:0] gain3_o,        // twelfths
  output logic off2_neg_o,           // sign
  output logic [2:0] off2_steps_o,   // 0.2 steps
  output logic off3_neg_o,           // sign
  output logic [5:0] off3_o          // twelfths
);
  // bypassed stages report unity gain and no offset
  always_comb begin
    mod_en_o = enable_i[0];
    bypass_o = ~enable_i[3:1];
    gain1_o = enable_i[1] ? (first_gain_i ? GAIN1_HI_X12 : GAIN1_LO_X12) : GAIN1_LO_X12;
    case (second_gain_i)
      2'h0: gain2_o = GAIN2_00_X12;
      2'h1: gain2_o = GAIN2_01_X12;
      2'h2: gain2_o = GAIN2_10_X12;
      2'h3: gain2_o = GAIN2_11_X12;
      default: gain2_o = GAIN2_00_X12;
    endcase
    if (!enable_i[2]) begin
      gain2_o = GAIN2_00_X12;
    end
    off2_neg_o = enable_i[2] & second_off_i[3];
    // magnitudes above five are clamped to full scale
    off2_steps_o = !enable_i[2] ? 3'h0 :
                   ((second_off_i[2:0] > OFF2_MAG_MAX[2:0]) ? OFF2_MAG_MAX[2:0] : second_off_i[2:0]);
    gain3_o = enable_i[3] ? third_gain_i : 7'h0c;
    off3_neg_o = enable_i[3] & third_off_i[6];
    off3_o = enable_i[3] ? third_off_i[5:0] : 6'h00;
  end
endmodule
`default_nettype wire

// file: hw/acm_mux_dec.sv
/*
  combinational decode of input-select and reference-select into pin numbers.
  assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module acm_mux_dec
  import acm_pkg::*;
(
  input wire logic [4:0] input_select_field_i, // input mux code
  input wire logic reference_select_bit_i,     // reference pair code
  output logic [2:0] pos_pin_o,                // positive pin
  output logic [2:0] neg_pin_o,                // negative pin
  output logic [1:0] ref_pair_o                // reference pair
);
  logic [2:0] p_raw; // before swap
  logic [2:0] n_raw;

  // table lookup, then optional swap
  always_comb begin
    p_raw = PIN_AC0;
    n_raw = PIN_AC0;
    if (input_select_field_i[4]) begin
      // single ended against input zero; codes 6,7 fall back to input zero
      p_raw = (input_select_field_i[2:0] > 3'h5) ? PIN_AC0 : input_select_field_i[2:0];
      n_raw = PIN_AC0;
    end else begin
      case (input_select_field_i[1:0])
        SEL_PAIR_10: begin
          p_raw = 3'h1;
          n_raw = 3'h0;
        end
        SEL_PAIR_32: begin
          p_raw = 3'h3;
          n_raw = 3'h2;
        end
        SEL_PAIR_54: begin
          p_raw = 3'h5;
          n_raw = 3'h4;
        end
        default: begin
          p_raw = PIN_AC0; // unlisted code shorts inputs
          n_raw = PIN_AC0;
        end
      endcase
    end
    pos_pin_o = input_select_field_i[3] ? n_raw : p_raw;
    neg_pin_o = input_select_field_i[3] ? p_raw : n_raw;
    ref_pair_o = reference_select_bit_i ? 2'h1 : 2'h0;
  end
endmodule
`default_nettype wire

// file: hw/acm_pkg.sv
/*
  package for the acquisition chain control block: register indices, field
  positions, reset values, mux codes, gain tables and carrier structs.
  assumes a single 25 MHz clock domain and an 8-bit register port.
*/
package acm_pkg;

  // register indices on the 8-bit register port
  localparam logic [2:0] ADDR_CHAIN_CONFIG_ZERO = 3'h0;
  localparam logic [2:0] ADDR_BLOCK_ENABLE_BIAS = 3'h1;
  localparam logic [2:0] ADDR_STAGE2_GAIN_OFFSET_RATE = 3'h2;
  localparam logic [2:0] ADDR_STAGE1_STAGE3_GAIN = 3'h3;
  localparam logic [2:0] ADDR_STAGE3_OFFSET = 3'h4;
  localparam logic [2:0] ADDR_INPUT_REFERENCE_SELECT = 3'h5;
  localparam logic [2:0] ADDR_RESULT_LSB = 3'h6;
  localparam logic [2:0] ADDR_RESULT_MSB = 3'h7;

  // field positions
  localparam int POS_START = 7;
  localparam int POS_REPEAT_MODE = 1;
  localparam int POS_BUSY = 7;
  localparam int POS_DEFAULTS = 6;
  localparam int POS_FIRST_STAGE_GAIN = 7;
  localparam int POS_REFERENCE_SELECT = 0;

  // reset values
  localparam logic [7:0] RST_CHAIN_CONFIG_ZERO = 8'h28;
  localparam logic [7:0] RST_BLOCK_ENABLE_BIAS = 8'h00;
  localparam logic [7:0] RST_STAGE2_GAIN_OFFSET_RATE = 8'h00;
  localparam logic [7:0] RST_STAGE1_STAGE3_GAIN = 8'h0c;
  localparam logic [7:0] RST_STAGE3_OFFSET = 8'h00;
  localparam logic [7:0] RST_INPUT_REFERENCE_SELECT = 8'h00;
  // defaults loaded by the defaults strobe: pga off, max speed, nominal bias
  localparam logic [7:0] DEF_BLOCK_ENABLE_BIAS = 8'hc1;
  localparam logic [7:0] DEF_STAGE2_GAIN_OFFSET_RATE = 8'hc0;

  // conversion length in cycles (stand-in for the real timing)
  localparam int CONV_TIME_NS = 4000;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [7:0] CONV_CYCLES = 8'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // analog mux pin numbers
  localparam logic [2:0] PIN_AC0 = 3'h0;
  localparam logic [1:0] SEL_PAIR_10 = 2'h0;
  localparam logic [1:0] SEL_PAIR_32 = 2'h1;
  localparam logic [1:0] SEL_PAIR_54 = 2'h2;

  // gains in twelfths so all stages share one unit
  localparam logic [7:0] GAIN1_LO_X12 = 8'h0c;
  localparam logic [7:0] GAIN1_HI_X12 = 8'h78;
  localparam logic [7:0] GAIN2_00_X12 = 8'h0c;
  localparam logic [7:0] GAIN2_01_X12 = 8'h18;
  localparam logic [7:0] GAIN2_10_X12 = 8'h3c;
  localparam logic [7:0] GAIN2_11_X12 = 8'h78;
  localparam logic [3:0] OFF2_MAG_MAX = 4'h5;

  // conversion sequencer states, gray along idle -> run -> done
  typedef enum logic [1:0] {
    ACM_IDLE = 2'b00,
    ACM_RUN  = 2'b01,
    ACM_DONE = 2'b11
  } acm_state_t;

  // decoded analog settings handed to the amplifier/converter
  typedef struct packed {
    logic [2:0] pos_pin;      // positive mux input, 0..5
    logic [2:0] neg_pin;      // negative mux input, 0..5
    logic [1:0] ref_pair;     // 0: pair 1-0, 1: pair 3-2
    logic mod_en;             // modulator enable
    logic [2:0] stage_bypass; // bit i: stage i+1 bypassed
    logic [7:0] gain1_x12;    // stage 1 gain in twelfths
    logic [7:0] gain2_x12;    // stage 2 gain in twelfths
    logic [6:0] gain3_x12;    // stage 3 gain in twelfths
    logic off2_neg;           // stage 2 offset sign
    logic [2:0] off2_steps;   // stage 2 offset in 0.2 steps
    logic off3_neg;           // stage 3 offset sign
    logic [5:0] off3_x12;     // stage 3 offset in twelfths
  } acm_analog_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } acm_reg_req_t;

endpackage
